// File: periph_reset_pkg.sv
// shared constants and types for the peripheral soft reset controller
package periph_reset_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFFS_PERIPH_ONE = 12'h044;
  localparam logic [ADDR_W-1:0] OFFS_GPIO_PORT = 12'h048;

  localparam logic [DATA_W-1:0] RESET_VALUE = 32'h0000_0000;

  // field positions, first register
  localparam int unsigned BIT_COMP_ZERO = 24;
  localparam int unsigned BIT_COMP_ONE = 25;
  localparam int unsigned BIT_COMP_TWO = 26;
  localparam int unsigned BIT_TIMER_ZERO = 16;
  localparam int unsigned BIT_TIMER_ONE = 17;
  localparam int unsigned BIT_TIMER_TWO = 18;
  localparam int unsigned BIT_TWO_WIRE = 12;
  localparam int unsigned BIT_SYNC_SERIAL = 4;
  localparam int unsigned BIT_ASYNC_ONE = 1;
  localparam int unsigned BIT_ASYNC_ZERO = 0;

  // writable bits of each register; all others reserved
  localparam logic [DATA_W-1:0] IMPL_PERIPH_ONE = 32'h0707_1013;
  localparam logic [DATA_W-1:0] IMPL_GPIO_PORT = 32'h0000_001f;

  localparam int unsigned NUM_PORTS = 5;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // per-peripheral reset outputs of the first register
  typedef struct packed {
    logic comparator_two_reset;
    logic comparator_one_reset;
    logic comparator_zero_reset;
    logic gp_counter_two_reset;
    logic gp_counter_one_reset;
    logic gp_counter_zero_reset;
    logic two_wire_unit_reset;
    logic sync_serial_unit_reset;
    logic async_serial_one_reset;
    logic async_serial_zero_reset;
  } periph_resets_t;

  // port e down to port a
  typedef struct packed {
    logic port_e_reset;
    logic port_d_reset;
    logic port_c_reset;
    logic port_b_reset;
    logic port_a_reset;
  } port_resets_t;

endpackage

// File: reset_ctrl_reg.sv
// one masked software reset control register
`timescale 1ns/100ps
`default_nettype none
module reset_ctrl_reg #(
  parameter int unsigned WIDTH = 32,
  parameter logic [WIDTH-1:0] IMPL = '1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic wr_en, // one-cycle write strobe
  input wire logic [WIDTH-1:0] wr_data, // data after byte strobes merged
  input wire logic [WIDTH-1:0] cap_mask, // capability register contents
  output logic [WIDTH-1:0] value // current register contents
);

  logic [WIDTH-1:0] value_q;
  logic [WIDTH-1:0] value_d;
  logic [WIDTH-1:0] keep;

  always_comb begin
    // only present units on implemented bits may change
    keep = IMPL & cap_mask;
    value_d = value_q;
    if (wr_en) begin
      value_d = (value_q & ~keep) | (wr_data & keep);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      value_q <= RST_VAL;
    end else begin
      value_q <= value_d;
    end
  end

  assign value = value_q;

  property p_reserved_zero;
    @(posedge clk) disable iff (!nrst)
      (value_q & ~IMPL) == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit became set");

  property p_masked_stable;
    @(posedge clk) disable iff (!nrst)
      1'b1 |=> ((value_q ^ $past(value_q)) & ~$past(cap_mask)) == '0;
  endproperty
  a_masked_stable: assert property (p_masked_stable)
    else $error("bit changed without capability");

endmodule
`default_nettype wire

// File: peripheral_soft_reset_ctrl.sv
// peripheral soft reset controller with axi4-lite register slave
// Functional notes
// - A write changes a control bit only where the matching capability bit is one.
// - Comparator two, one and zero resets sit at bits 26, 25 and 24 of the first register.
// - Timer two, one and zero resets sit at bits 18, 17 and 16 of the first register.
// - Two-wire at bit 12, sync serial at bit 4, async serial at bits 1 and 0 of the first register.
// - Port e to port a resets sit at bits 4 to 0 of the second register, 31 to 5 reserved.
// - Reserved bits read zero and ignore writes; software should preserve them.
// - Both registers clear to zero on system reset.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module peripheral_soft_reset_ctrl
  import periph_reset_pkg::*;
(
  input wire logic clk, // 200 mhz system clock
  input wire logic nrst, // async reset, active low
  input wire logic [periph_reset_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [periph_reset_pkg::DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [periph_reset_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [periph_reset_pkg::DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [periph_reset_pkg::DATA_W-1:0] capability_mask_two, // present units
  input wire logic [periph_reset_pkg::DATA_W-1:0] capability_mask_four, // present ports
  output periph_reset_pkg::periph_resets_t periph_resets, // peripheral resets, high = held
  output periph_reset_pkg::port_resets_t port_resets // port resets, high = held
);
  import periph_reset_pkg::*;

  // write channel state
  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic [ADDR_W-1:0] waddr_q, waddr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  // read channel state
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  // output state
  periph_resets_t periph_q, periph_d;
  port_resets_t port_q, port_d;

  logic aw_take, w_take, ar_take, do_write, wr_one, wr_port;
  logic awready_q, wready_q, arready_q;
  logic [DATA_W-1:0] cur_one, cur_port, merged;
  logic [DATA_W-1:0] byte_mask;

  // take only on a real valid/ready handshake; ready is low in the cycle after reset
  assign aw_take = s_axi_awvalid && awready_q;
  assign w_take = s_axi_wvalid && wready_q;
  assign ar_take = s_axi_arvalid && arready_q;

  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    if (aw_take) begin
      aw_held_d = 1'b1;
      waddr_d = s_axi_awaddr;
    end
    if (w_take) begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
    end
  end

  // write commits one cycle after both halves are held
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign wr_one = do_write && (waddr_q[ADDR_W-1:2] == OFFS_PERIPH_ONE[ADDR_W-1:2]);
  assign wr_port = do_write && (waddr_q[ADDR_W-1:2] == OFFS_GPIO_PORT[ADDR_W-1:2]);

  generate
    for (genvar i = 0; i < 4; i++) begin : g_lane
      assign byte_mask[8*i +: 8] = {8{wstrb_q[i]}};
    end
  endgenerate

  // unstrobed bytes keep their old value; cheaper than a per-byte enable
  always_comb begin
    merged = wr_port ? cur_port : cur_one;
    merged = (merged & ~byte_mask) | (wdata_q & byte_mask);
  end

  always_comb begin
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (do_write) begin
      bvalid_d = 1'b1;
      bresp_d = (wr_one || wr_port) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  reset_ctrl_reg #(
    .WIDTH(DATA_W),
    .IMPL(IMPL_PERIPH_ONE),
    .RST_VAL(RESET_VALUE)
  ) u_periph_one (
    .clk(clk),
    .nrst(nrst),
    .wr_en(wr_one),
    .wr_data(merged),
    .cap_mask(capability_mask_two),
    .value(cur_one)
  );

  reset_ctrl_reg #(
    .WIDTH(DATA_W),
    .IMPL(IMPL_GPIO_PORT),
    .RST_VAL(RESET_VALUE)
  ) u_gpio_port (
    .clk(clk),
    .nrst(nrst),
    .wr_en(wr_port),
    .wr_data(merged),
    .cap_mask(capability_mask_four),
    .value(cur_port)
  );

  // read path: one read in flight, answered the cycle after the arvalid/arready handshake
  always_comb begin
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (ar_take) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      if (s_axi_araddr[ADDR_W-1:2] == OFFS_PERIPH_ONE[ADDR_W-1:2]) begin
        rdata_d = cur_one;
      end else if (s_axi_araddr[ADDR_W-1:2] == OFFS_GPIO_PORT[ADDR_W-1:2]) begin
        rdata_d = cur_port;
      end else begin
        rdata_d = '0;
        rresp_d = RESP_SLVERR;
      end
    end
  end

  // reset outputs follow the stored bits, registered
  always_comb begin
    periph_d.comparator_two_reset = cur_one[BIT_COMP_TWO];
    periph_d.comparator_one_reset = cur_one[BIT_COMP_ONE];
    periph_d.comparator_zero_reset = cur_one[BIT_COMP_ZERO];
    periph_d.gp_counter_two_reset = cur_one[BIT_TIMER_TWO];
    periph_d.gp_counter_one_reset = cur_one[BIT_TIMER_ONE];
    periph_d.gp_counter_zero_reset = cur_one[BIT_TIMER_ZERO];
    periph_d.two_wire_unit_reset = cur_one[BIT_TWO_WIRE];
    periph_d.sync_serial_unit_reset = cur_one[BIT_SYNC_SERIAL];
    periph_d.async_serial_one_reset = cur_one[BIT_ASYNC_ONE];
    periph_d.async_serial_zero_reset = cur_one[BIT_ASYNC_ZERO];
    port_d = port_resets_t'(cur_port[NUM_PORTS-1:0]);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
      periph_q <= '0;
      port_q <= '0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      periph_q <= periph_d;
      port_q <= port_d;
    end
  end

  // readies are registered copies of "slot free" so outputs stay flop-driven
  logic awready_d, wready_d, arready_d;
  assign awready_d = !aw_held_d && !bvalid_d;
  assign wready_d = !w_held_d && !bvalid_d;
  assign arready_d = !rvalid_d;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
    end else begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_arready = arready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign periph_resets = periph_q;
  assign port_resets = port_q;

  // assertions
  sequence s_one_written;
    wr_one && wdata_q[BIT_TIMER_ZERO] && wstrb_q[2] && capability_mask_two[BIT_TIMER_ZERO];
  endsequence

  property p_timer_held;
    @(posedge clk) disable iff (!nrst)
      s_one_written |=> ##1 periph_resets.gp_counter_zero_reset;
  endproperty
  a_timer_held: assert property (p_timer_held)
    else $error("timer zero not held in reset after write");

  property p_port_follow;
    @(posedge clk) disable iff (!nrst)
      1'b1 |=> port_resets == port_resets_t'($past(cur_port[NUM_PORTS-1:0]));
  endproperty
  a_port_follow: assert property (p_port_follow)
    else $error("port reset outputs do not follow register");

  property p_comp_follow;
    @(posedge clk) disable iff (!nrst)
      1'b1 |=> periph_resets.comparator_two_reset == $past(cur_one[BIT_COMP_TWO]);
  endproperty
  a_comp_follow: assert property (p_comp_follow)
    else $error("comparator two reset mismatch");

  property p_read_zero_reserved;
    @(posedge clk) disable iff (!nrst)
      rvalid_q |-> (rdata_q & ~(IMPL_PERIPH_ONE | IMPL_GPIO_PORT)) == '0;
  endproperty
  a_read_zero_reserved: assert property (p_read_zero_reserved)
    else $error("reserved bits read nonzero");

  property p_no_cap_no_change;
    @(posedge clk) disable iff (!nrst)
      !capability_mask_four[0] |=> cur_port[0] == $past(cur_port[0]);
  endproperty
  a_no_cap_no_change: assert property (p_no_cap_no_change)
    else $error("port a bit changed without capability");

  property p_bresp_after_write;
    @(posedge clk) disable iff (!nrst)
      do_write |=> s_axi_bvalid ##0 (s_axi_bresp == (($past(wr_one) || $past(wr_port)) ? RESP_OKAY : RESP_SLVERR));
  endproperty
  a_bresp_after_write: assert property (p_bresp_after_write)
    else $error("write response missing or wrong");

  property p_release;
    @(posedge clk) disable iff (!nrst)
      $fell(cur_one[BIT_TWO_WIRE]) |=> !periph_resets.two_wire_unit_reset;
  endproperty
  a_release: assert property (p_release)
    else $error("two-wire unit not released");

  property p_reset_clear;
    @(posedge clk) $rose(nrst) |-> cur_one == RESET_VALUE && cur_port == RESET_VALUE;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("registers not clear after reset");

  property p_aw_handshake;
    @(posedge clk) disable iff (!nrst)
      $rose(aw_held_q) |-> $past(s_axi_awvalid) && $past(s_axi_awready);
  endproperty
  a_aw_handshake: assert property (p_aw_handshake)
    else $error("write address taken without ready");

  property p_read_answer;
    @(posedge clk) disable iff (!nrst)
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read taken but not answered");

endmodule
`default_nettype wire

// File: peripheral_soft_reset_ctrl_tb.sv
// self-checking testbench for the peripheral soft reset controller
`timescale 1ns/100ps
`default_nettype none
module peripheral_soft_reset_ctrl_tb;
  import periph_reset_pkg::*;
  logic clk;
  logic nrst;
  logic [ADDR_W-1:0] awaddr;
  logic [ADDR_W-1:0] araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [DATA_W-1:0] cap_two;
  logic [DATA_W-1:0] cap_four;
  periph_resets_t periph_resets;
  port_resets_t port_resets;
  logic [31:0] sh_one;
  logic [31:0] sh_two;
  logic [31:0] rd_v;
  logic [1:0] rs_v;
  int fails;
  int checks_done;

  peripheral_soft_reset_ctrl peripheral_soft_reset_ctrl_i (
    .clk(clk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .capability_mask_two(cap_two), .capability_mask_four(cap_four),
    .periph_resets(periph_resets), .port_resets(port_resets)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bound(input int n);
    if (n > 50) begin
      fails++;
      finish_test();
    end
  endtask

  // ready is registered, so its value at the falling edge is what the next rising edge samples
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] resp);
    int n;
    logic aw_hs;
    logic w_hs;
    logic got;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      @(posedge clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      bound(++n);
    end while ((awvalid && !aw_hs) || (wvalid && !w_hs));
    bready <= 1'b1;
    do begin
      @(negedge clk);
      got = bvalid;
      resp = bresp;
      @(posedge clk);
      bound(++n);
    end while (!got);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    logic hs;
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      hs = arready;
      @(posedge clk);
      bound(++n);
    end while (!hs);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      hs = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge clk);
      bound(++n);
    end while (!hs);
    rready <= 1'b0;
  endtask

  // reads a register back and compares the reset outputs against both shadows
  task automatic rd_chk(input logic sel);
    axi_read(sel ? OFFS_GPIO_PORT : OFFS_PERIPH_ONE, rd_v, rs_v);
    check({30'h0, rs_v}, {30'h0, RESP_OKAY});
    check(rd_v, sel ? sh_two : sh_one);
    check({17'h0, periph_resets, port_resets}, {17'h0, sh_one[26], sh_one[25], sh_one[24],
          sh_one[18], sh_one[17], sh_one[16], sh_one[12], sh_one[4], sh_one[1], sh_one[0],
          sh_two[4:0]});
  endtask

  task automatic wr_chk(input logic sel, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    logic [31:0] m;
    logic [31:0] mrg;
    axi_write(sel ? OFFS_GPIO_PORT : OFFS_PERIPH_ONE, d, s, rs_v);
    check({30'h0, rs_v}, {30'h0, RESP_OKAY});
    // masks changed just before the call are only settled now
    q = sel ? sh_two : sh_one;
    m = sel ? (cap_four & IMPL_GPIO_PORT) : (cap_two & IMPL_PERIPH_ONE);
    for (int b = 0; b < 4; b++) mrg[b*8+:8] = s[b] ? d[b*8+:8] : q[b*8+:8];
    q = (q & ~m) | (mrg & m);
    if (sel) sh_two = q;
    else sh_one = q;
    rd_chk(sel);
  endtask

  initial begin
    logic [11:0] bad [3];
    bad = '{12'h040, 12'h04c, 12'h000};
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    cap_two = '1;
    cap_four = '1;
    sh_one = 32'h0;
    sh_two = 32'h0;
    fails = 0;
    checks_done = 0;
    nrst = 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_chk(1'b0);
    rd_chk(1'b1);
    // single-bit walk through every position, reserved ones included
    for (int i = 0; i < 32; i++) begin
      wr_chk(1'b0, 32'h1 << i, 4'hf);
      wr_chk(1'b1, 32'h1 << i, 4'hf);
    end
    wr_chk(1'b0, 32'hffff_ffff, 4'hf);
    wr_chk(1'b1, 32'hffff_ffff, 4'hf);
    wr_chk(1'b0, 32'h0, 4'b0100);
    wr_chk(1'b0, 32'h0, 4'b1000);
    // absent units keep their bits through a write
    cap_two <= 32'h0500_1001;
    cap_four <= 32'h0000_000a;
    wr_chk(1'b0, 32'h0, 4'hf);
    wr_chk(1'b1, 32'h0, 4'hf);
    wr_chk(1'b0, 32'hffff_ffff, 4'hf);
    cap_two <= 32'h0;
    wr_chk(1'b0, 32'h0, 4'hf);
    cap_two <= '1;
    cap_four <= '1;
    wr_chk(1'b1, 32'h0000_0015, 4'hf);
    // unmapped addresses are refused and leave both registers alone
    foreach (bad[k]) begin
      axi_write(bad[k], 32'hffff_ffff, 4'hf, rs_v);
      check({30'h0, rs_v}, {30'h0, RESP_SLVERR});
      axi_read(bad[k], rd_v, rs_v);
      check({30'h0, rs_v}, {30'h0, RESP_SLVERR});
      check(rd_v, 32'h0);
    end
    rd_chk(1'b0);
    rd_chk(1'b1);
    // second reset in mid-run
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    sh_one = 32'h0;
    sh_two = 32'h0;
    check({17'h0, periph_resets, port_resets}, 32'h0);
    check({27'h0, awready, wready, arready, bvalid, rvalid}, 32'h0);
    nrst <= 1'b1;
    @(posedge clk);
    rd_chk(1'b0);
    rd_chk(1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
